// File: core/rcds_top.sv
// Purpose: Reset cause flags and release sequencing of the master system reset
// Assumes: Event inputs are one-cycle pulses from logic on clk_sys_i;
//          reset_n_i is the power-on reset itself
// Notes:   Avalon-MM slave, one wait state per access
//
// What this block does
// - Trap conflict sets bit 15; power/brownout clears.
// - Bad opcode or pointer sets bit 14.
// - Bits 13 to 10 read zero.
// - Config mismatch sets bit 9.
// - Bit 8 keeps regulator active in sleep.
// - Pin reset sets bit 7; brownout keeps it.
// - Reset instruction sets bit 6.
// - Bit 5 enables watchdog unless fuse forces it.
// - Time-out sets bit 4; power-save or clear clears.
// - Sleep sets bit 3, idle sets bit 2.
// - Brownout bit 1, power-on bit 0, cleared only by software.
// - Software writes any flag without causing reset.
// - Power resets take fuse clock, others current.
// - Switching disabled: always the fuse clock.
// - Power resets release only after power and start-up delays.
// - Power-on adds 10 us; brownout skips it.
// - Start-up 20 us or 64 ms; wake too, regulator on only.
// - Other resets hold only 20 us state time.
// - Crystal sources wait 1024 oscillator periods.
// - Loop sources add 20 us lock wait.
// - Clock waits run alongside the reset delay.
// - After power resets, crystal or loop: monitor starts 100 us later.
// - Any active reset source asserts system reset.
// - Power-on clears all flags, sets power-on and brownout flags.
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rcds_defs.svh"
module rcds_top #(
  parameter int PUT_US = `RCDS_T_PUT_US      // Long start-up delay in us
) (
  input  wire logic        clk_sys_i,             // System clock, 10 MHz
  input  wire logic        reset_n_i,             // Power-on reset, active low
  input  wire logic [2:0]  avs_address_i,         // Byte address
  input  wire logic        avs_read_i,            // Read request
  input  wire logic        avs_write_i,           // Write request
  input  wire logic [31:0] avs_writedata_i,       // Write data
  input  wire logic [3:0]  avs_byteenable_i,      // Byte lanes
  output logic [31:0]      avs_readdata_o,        // Read data
  output logic             avs_waitrequest_o,     // Stall
  input  wire logic        master_clear_pin_n_i,  // External reset pin, low active
  input  wire logic        osc_pin_i,             // Oscillator clock pin
  input  wire logic        brownout_i,            // Brown-out event
  input  wire logic        trap_conflict_i,       // Trap conflict event
  input  wire logic        bad_opcode_i,          // Illegal opcode or pointer
  input  wire logic        config_mismatch_i,     // Configuration mismatch
  input  wire logic        soft_reset_i,          // Reset instruction
  input  wire logic        watchdog_timeout_i,    // Watchdog time-out
  input  wire logic        save_sleep_i,          // Power-save sleep instruction
  input  wire logic        save_idle_i,           // Power-save idle instruction
  input  wire logic        watchdog_clear_i,      // Watchdog clear instruction
  input  wire logic        wake_i,                // Wake from sleep
  input  wire logic        watchdog_fuse_enable_i,// Fuse forces watchdog on
  input  wire logic [2:0]  fuse_clock_select_i,   // Fuse clock source
  input  wire logic [2:0]  current_clock_select_i,// Oscillator control source
  input  wire logic        clock_switch_en_i,     // Clock switching allowed
  input  wire logic        primary_crystal_i,     // Primary source is a crystal
  input  wire logic        regulator_enable_i,    // On-chip regulator on
  output logic             master_system_reset_o, // System reset, high active
  output logic [2:0]       clock_select_o,        // Clock source applied
  output logic             clock_ready_o,         // Clock passed to system
  output logic             monitor_enable_o,      // Clock monitor may run
  output logic             watchdog_enable_o,     // Watchdog enabled
  output logic             regulator_sleep_keep_o,// Regulator active in sleep
  output logic             wake_hold_o            // Wake start-up running
);

  localparam logic [15:0] PUT_TICKS = 16'(`RCDS_TICKS(PUT_US));    // Long start-up
  localparam logic [15:0] PON_TICKS = 16'(`RCDS_TICKS(`RCDS_T_PON_US));
  localparam logic [15:0] STA_TICKS = 16'(`RCDS_TICKS(`RCDS_T_START_US));
  localparam logic [15:0] RST_TICKS = 16'(`RCDS_TICKS(`RCDS_T_RST_US));
  localparam logic [15:0] LCK_TICKS = 16'(`RCDS_TICKS(`RCDS_T_LOCK_US));
  localparam logic [15:0] MON_TICKS = 16'(`RCDS_TICKS(`RCDS_T_MON_US));
  localparam logic [3:0]  PRESC_LAST = 4'(`RCDS_REF_DIV - 1);

  rcds_pkg::rcds_top_st_t s_ff;   // Registered state
  rcds_pkg::rcds_top_st_t nxt_s;  // Next state

  logic        ref_tick;    // 1 us reference enable
  logic        seq_done;    // Sequencer delay expired
  logic        lock_done;   // Lock wait expired
  logic        mon_done;    // Monitor wait expired
  logic        seq_load;    // Start sequencer delay
  logic [15:0] seq_val;     // Sequencer delay value
  logic        lock_load;   // Start lock wait
  logic [15:0] lock_val;    // Lock wait value
  logic        mon_load;    // Start monitor wait
  logic [15:0] mon_val;     // Monitor wait value
  logic        bus_req;     // Read or write pending
  logic        bus_go;      // Access completes this cycle
  logic [31:0] rd_mux;      // Read data source
  logic [15:0] wmask;       // Written bits of the cause register
  logic        clr_active;  // Filtered pin reset active
  logic        osc_rise;    // Filtered oscillator rising edge
  logic        short_rst;   // Any non-power reset source
  logic [2:0]  sel_now;     // Source the clock path judges
  logic        need_settle; // Source is a crystal
  logic        need_lock;   // Source uses the loop
  logic        in_reset;    // System reset asserted
  logic        clk_ready;   // Clock waits finished
  logic [15:0] start_ticks; // Start-up delay for this regulator mode

  // Reference tick: the one always-running time base for all delays
  assign ref_tick = (s_ff.presc == PRESC_LAST);

  // Reset stays asserted in every phase but run and wake
  assign in_reset = (s_ff.st != rcds_pkg::ST_RUN) && (s_ff.st != rcds_pkg::ST_WAKE);

  // Regulator on: short start-up; off: power-up timer
  assign start_ticks = regulator_enable_i ? STA_TICKS : PUT_TICKS;

  // Pin reset counts only once the filter agrees
  assign clr_active = !s_ff.clr_lvl;

  // Rising edge seen on the filtered oscillator level
  assign osc_rise = (s_ff.osc_sy[1] == s_ff.osc_sy[2]) && s_ff.osc_sy[2] && !s_ff.osc_lvl;

  // Every source other than power-on and brown-out
  assign short_rst = clr_active | watchdog_timeout_i | soft_reset_i |
                     trap_conflict_i | bad_opcode_i | config_mismatch_i;

  // During power-on the fuse field is judged directly, so waits start at once
  assign sel_now = (s_ff.st == rcds_pkg::ST_PON) ? fuse_clock_select_i : s_ff.clk_sel;

  // Crystal and secondary sources need the settle count
  assign need_settle = (sel_now == `RCDS_CLK_SOSC) ||
                       (primary_crystal_i &&
                        ((sel_now == `RCDS_CLK_PRI) || (sel_now == `RCDS_CLK_PRIPLL)));

  // Loop-based sources need the lock wait
  assign need_lock = (sel_now == `RCDS_CLK_FRCPLL) || (sel_now == `RCDS_CLK_PRIPLL);

  assign clk_ready = s_ff.settle_done && s_ff.lock_go && lock_done;

  // Bus handshake: one wait state, answer on the second edge
  assign bus_req = avs_read_i | avs_write_i;
  assign bus_go  = bus_req & s_ff.ack;

  // Byte lanes mapped onto the 16-bit register
  assign wmask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  // Read data selection; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0;
    case (avs_address_i)
      `RCDS_ADDR_CAUSE: begin
        rd_mux = {16'h0, s_ff.cause & `RCDS_IMPL_MASK};
      end
      `RCDS_ADDR_STATUS: begin
        rd_mux = {25'h0, watchdog_enable_o, monitor_enable_o, in_reset,
                  clk_ready, s_ff.clk_sel};
      end
      default: begin
        rd_mux = 32'h0;
      end
    endcase
  end

  // Next-state logic of the whole block
  always_comb begin
    nxt_s     = s_ff;
    seq_load  = 1'b0;
    seq_val   = 16'h0;
    lock_load = 1'b0;
    lock_val  = 16'h0;
    mon_load  = 1'b0;
    mon_val   = 16'h0;

    // Pin synchronisers; a change counts when second and third agree
    nxt_s.clr_sy = {s_ff.clr_sy[1:0], master_clear_pin_n_i};
    if (s_ff.clr_sy[1] == s_ff.clr_sy[2]) begin
      nxt_s.clr_lvl = s_ff.clr_sy[2];
    end
    nxt_s.osc_sy = {s_ff.osc_sy[1:0], osc_pin_i};
    if (s_ff.osc_sy[1] == s_ff.osc_sy[2]) begin
      nxt_s.osc_lvl = s_ff.osc_sy[2];
    end

    // Reference divider
    nxt_s.presc = ref_tick ? 4'h0 : s_ff.presc + 4'h1;

    // Bus: capture read data on the first cycle of a request
    nxt_s.ack = bus_req & !s_ff.ack;
    if (bus_req && !s_ff.ack) begin
      nxt_s.rdata = rd_mux;
    end

    // Software write to the cause register; it never starts a reset
    if (bus_go && avs_write_i && (avs_address_i == `RCDS_ADDR_CAUSE)) begin
      nxt_s.cause = (s_ff.cause & ~wmask) | (avs_writedata_i[15:0] & wmask);
    end

    // Clearing events come first so a same-cycle set wins
    if (brownout_i) begin
      nxt_s.cause = nxt_s.cause & ~`RCDS_BRN_CLR_MASK;
    end
    if (save_sleep_i || save_idle_i || watchdog_clear_i) begin
      nxt_s.cause[`RCDS_B_WTO] = 1'b0;
    end

    // Setting events
    if (trap_conflict_i) begin
      nxt_s.cause[`RCDS_B_TRAP] = 1'b1;
    end
    if (bad_opcode_i) begin
      nxt_s.cause[`RCDS_B_OPC] = 1'b1;
    end
    if (config_mismatch_i) begin
      nxt_s.cause[`RCDS_B_CFG] = 1'b1;
    end
    if (clr_active) begin
      nxt_s.cause[`RCDS_B_EXT] = 1'b1;
    end
    if (soft_reset_i) begin
      nxt_s.cause[`RCDS_B_SOFT] = 1'b1;
    end
    if (watchdog_timeout_i) begin
      nxt_s.cause[`RCDS_B_WTO] = 1'b1;
    end
    if (save_sleep_i) begin
      nxt_s.cause[`RCDS_B_SLP] = 1'b1;
    end
    if (save_idle_i) begin
      nxt_s.cause[`RCDS_B_IDL] = 1'b1;
    end
    if (brownout_i) begin
      nxt_s.cause[`RCDS_B_BRN] = 1'b1;
    end
    nxt_s.cause = nxt_s.cause & `RCDS_IMPL_MASK;

    // Clock path runs beside the reset delay, not after it
    if (!s_ff.settle_done && need_settle && osc_rise) begin
      nxt_s.settle_cnt = s_ff.settle_cnt + 10'h1;
    end
    nxt_s.settle_done = s_ff.settle_done || !need_settle ||
                        (osc_rise && (s_ff.settle_cnt == `RCDS_SETTLE_LAST));
    if (s_ff.settle_done && !s_ff.lock_go) begin
      lock_load     = 1'b1;
      lock_val      = need_lock ? LCK_TICKS : 16'h0;
      nxt_s.lock_go = 1'b1;
    end

    // Sequencer; brown-out outranks the short resets
    if (brownout_i) begin
      nxt_s.st          = rcds_pkg::ST_START;
      seq_load          = 1'b1;
      seq_val           = start_ticks;
      nxt_s.clk_sel     = fuse_clock_select_i;
      nxt_s.pwr_path    = 1'b1;
      nxt_s.settle_cnt  = 10'h0;
      nxt_s.settle_done = 1'b0;
      nxt_s.lock_go     = 1'b0;
      nxt_s.mon_go      = 1'b0;
      lock_load         = 1'b0;
    end else if (short_rst) begin
      // Held and reloaded while the source stays active
      nxt_s.st       = rcds_pkg::ST_RST;
      seq_load       = 1'b1;
      seq_val        = RST_TICKS;
      nxt_s.clk_sel  = clock_switch_en_i ? current_clock_select_i
                                         : fuse_clock_select_i;
      nxt_s.pwr_path = 1'b0;
      nxt_s.mon_go   = 1'b0;
    end else begin
      case (s_ff.st)
        rcds_pkg::ST_PON: begin
          // Fuse source from the first edge after power-on reset; reset loads FRC
          nxt_s.clk_sel = fuse_clock_select_i;
          if (seq_done) begin
            nxt_s.st = rcds_pkg::ST_START;
            seq_load = 1'b1;
            seq_val  = start_ticks;
          end
        end
        rcds_pkg::ST_START: begin
          if (seq_done) begin
            nxt_s.st = rcds_pkg::ST_RST;
            seq_load = 1'b1;
            seq_val  = RST_TICKS;
          end
        end
        rcds_pkg::ST_RST: begin
          // Release; monitor waits only after power paths on slow sources
          if (seq_done) begin
            nxt_s.st     = rcds_pkg::ST_RUN;
            mon_load     = 1'b1;
            mon_val      = (s_ff.pwr_path && (need_settle || need_lock)) ? MON_TICKS : 16'h0;
            nxt_s.mon_go = 1'b1;
          end
        end
        rcds_pkg::ST_RUN: begin
          // Wake repeats the start-up delay only with the regulator on
          if (wake_i && regulator_enable_i) begin
            nxt_s.st = rcds_pkg::ST_WAKE;
            seq_load = 1'b1;
            seq_val  = STA_TICKS;
          end
        end
        rcds_pkg::ST_WAKE: begin
          if (seq_done) begin
            nxt_s.st = rcds_pkg::ST_RUN;
          end
        end
        default: begin
          nxt_s.st = rcds_pkg::ST_PON;
        end
      endcase
    end
  end

  // State register; power-on leaves only the two power flags set
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_ff.clr_sy      <= 3'h7;
      s_ff.clr_lvl     <= 1'b1;
      s_ff.osc_sy      <= 3'h0;
      s_ff.osc_lvl     <= 1'b0;
      s_ff.presc       <= 4'h0;
      s_ff.st          <= rcds_pkg::ST_PON;
      s_ff.cause       <= `RCDS_CAUSE_RESET;
      s_ff.clk_sel     <= `RCDS_CLK_FRC;
      s_ff.pwr_path    <= 1'b1;
      s_ff.settle_cnt  <= 10'h0;
      s_ff.settle_done <= 1'b0;
      s_ff.lock_go     <= 1'b0;
      s_ff.mon_go      <= 1'b0;
      s_ff.ack         <= 1'b0;
      s_ff.rdata       <= 32'h0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Sequencer delay; starts with the power-on delay at reset release
  rcds_delay_timer #(
    .W       (`RCDS_TMR_W),
    .RST_CNT (PON_TICKS)
  ) u_seq_timer (
    .clk_sys_i  (clk_sys_i),
    .reset_n_i  (reset_n_i),
    .tick_i     (ref_tick),
    .load_i     (seq_load),
    .load_val_i (seq_val),
    .done_o     (seq_done)
  );

  // Loop lock wait
  rcds_delay_timer #(
    .W       (`RCDS_TMR_W),
    .RST_CNT (16'h0)
  ) u_lock_timer (
    .clk_sys_i  (clk_sys_i),
    .reset_n_i  (reset_n_i),
    .tick_i     (ref_tick),
    .load_i     (lock_load),
    .load_val_i (lock_val),
    .done_o     (lock_done)
  );

  // Clock monitor start wait
  rcds_delay_timer #(
    .W       (`RCDS_TMR_W),
    .RST_CNT (16'h0)
  ) u_mon_timer (
    .clk_sys_i  (clk_sys_i),
    .reset_n_i  (reset_n_i),
    .tick_i     (ref_tick),
    .load_i     (mon_load),
    .load_val_i (mon_val),
    .done_o     (mon_done)
  );

  // Outputs
  assign master_system_reset_o  = in_reset;
  assign clock_select_o         = s_ff.clk_sel;
  assign clock_ready_o          = clk_ready;
  assign monitor_enable_o       = s_ff.mon_go && mon_done;
  assign watchdog_enable_o      = watchdog_fuse_enable_i | s_ff.cause[`RCDS_B_WDE];
  assign regulator_sleep_keep_o = s_ff.cause[`RCDS_B_VREG];
  assign wake_hold_o            = (s_ff.st == rcds_pkg::ST_WAKE);
  assign avs_readdata_o         = s_ff.rdata;
  assign avs_waitrequest_o      = bus_req & !s_ff.ack;

endmodule
`default_nettype wire

// File: core/rcds_defs.svh
// Purpose: Offsets, field positions, reset values and delays of the reset sequencer
// Assumes: 10 MHz system clock, 1 us reference tick
// Notes:   Included by bare name; definitions only
`ifndef RCDS_DEFS_SVH
`define RCDS_DEFS_SVH

// Avalon byte addresses
`define RCDS_ADDR_CAUSE   3'h0
`define RCDS_ADDR_STATUS  3'h4

// Cause/control register fields
`define RCDS_B_TRAP   15
`define RCDS_B_OPC    14
`define RCDS_B_CFG    9
`define RCDS_B_VREG   8
`define RCDS_B_EXT    7
`define RCDS_B_SOFT   6
`define RCDS_B_WDE    5
`define RCDS_B_WTO    4
`define RCDS_B_SLP    3
`define RCDS_B_IDL    2
`define RCDS_B_BRN    1
`define RCDS_B_PON    0
`define RCDS_CAUSE_RESET  16'h0003
`define RCDS_IMPL_MASK    16'hC3FF
`define RCDS_BRN_CLR_MASK 16'hC25C

// Clock source codes of the fuse and current-select fields
`define RCDS_CLK_FRC     3'h0
`define RCDS_CLK_FRCPLL  3'h1
`define RCDS_CLK_PRI     3'h2
`define RCDS_CLK_PRIPLL  3'h3
`define RCDS_CLK_SOSC    3'h4

// Timing
`define RCDS_CLK_HZ      10000000
`define RCDS_REF_HZ      1000000
`define RCDS_REF_DIV     (`RCDS_CLK_HZ / `RCDS_REF_HZ)
`define RCDS_PRESC_W     4
`define RCDS_TMR_W       16
`define RCDS_T_PON_US    10
`define RCDS_T_START_US  20
`define RCDS_T_PUT_US    64000
`define RCDS_T_RST_US    20
`define RCDS_T_LOCK_US   20
`define RCDS_T_MON_US    100
`define RCDS_TICKS(us)   ((us) * (`RCDS_REF_HZ / 1000000))
`define RCDS_SETTLE_LAST 10'h3FF

`endif

// File: core/rcds_pkg.sv
// Purpose: Types of the reset sequencer
// Assumes: Widths match rcds_defs.svh
// Notes:   Used as rcds_pkg::name, never imported
package rcds_pkg;

  // Sequencer phases, one-hot
  typedef enum logic [4:0] {
    ST_PON   = 5'h01,  // Power-on delay
    ST_START = 5'h02,  // Start-up delay
    ST_RST   = 5'h04,  // Internal state reset time
    ST_RUN   = 5'h08,  // Reset released
    ST_WAKE  = 5'h10   // Start-up delay on wake
  } rcds_state_t;

  // Whole state of the top module
  typedef struct packed {
    logic [2:0]  clr_sy;      // Master clear pin synchroniser
    logic        clr_lvl;     // Filtered master clear level
    logic [2:0]  osc_sy;      // Oscillator pin synchroniser
    logic        osc_lvl;     // Filtered oscillator level
    logic [3:0]  presc;       // Reference tick divider
    rcds_state_t st;          // Sequencer phase
    logic [15:0] cause;       // Cause/control register
    logic [2:0]  clk_sel;     // Clock source in use
    logic        pwr_path;    // Last reset was power-on or brown-out
    logic [9:0]  settle_cnt;  // Crystal settle counter
    logic        settle_done; // Crystal settle expired
    logic        lock_go;     // Lock wait started
    logic        mon_go;      // Monitor wait started
    logic        ack;         // Bus answer cycle
    logic [31:0] rdata;       // Bus read data
  } rcds_top_st_t;

endpackage

// File: core/rcds_delay_timer.sv
// Purpose: Down-counter stepped by the reference tick
// Assumes: tick_i is a one-cycle enable
// Notes:   done_o is high while the count is zero
`timescale 1ns/1ps
`default_nettype none
module rcds_delay_timer #(
  parameter int             W       = 16,  // Counter width
  parameter logic [W-1:0]   RST_CNT = '0   // Count held at reset
) (
  input  wire logic         clk_sys_i,     // System clock
  input  wire logic         reset_n_i,     // Async reset, active low
  input  wire logic         tick_i,        // Reference tick
  input  wire logic         load_i,        // Start a delay
  input  wire logic [W-1:0] load_val_i,    // Delay in ticks
  output logic              done_o         // Delay expired
);

  typedef struct packed {
    logic [W-1:0] cnt;  // Remaining ticks
  } rcds_tmr_t;

  rcds_tmr_t s_ff;      // Registered state
  rcds_tmr_t nxt_s;     // Next state

  // Load wins over a tick so a restart is never lost
  always_comb begin
    nxt_s = s_ff;
    if (load_i) begin
      nxt_s.cnt = load_val_i;
    end else if (tick_i && (s_ff.cnt != '0)) begin
      nxt_s.cnt = s_ff.cnt - 1'b1;
    end
  end

  // State register; reset starts the first delay at once
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_ff.cnt <= RST_CNT;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign done_o = (s_ff.cnt == '0);

endmodule
`default_nettype wire

// File: dv/rcds_props.sv
// Purpose: Port checker of the reset sequencer
// Assumes: 10 MHz clock, 1 us tick, start-up cut to 30 us
// Notes:   Each delay may run one tick short
`timescale 1ns/1ps
`default_nettype none
module rcds_props (
  input wire logic       clk_sys_i,              // Clock
  input wire logic       reset_n_i,              // Reset
  input wire logic       brownout_i,             // Event
  input wire logic       soft_reset_i,           // Event
  input wire logic       clock_switch_en_i,      // Level
  input wire logic       watchdog_fuse_enable_i, // Level
  input wire logic [2:0] fuse_clock_select_i,    // Level
  input wire logic       master_system_reset_o,  // Output
  input wire logic [2:0] clock_select_o,         // Output
  input wire logic       monitor_enable_o,       // Output
  input wire logic       watchdog_enable_o       // Output
);
  logic [9:0] run_ff; // Cycles since power-on, saturating
  // A plain delay cannot span the power-on hold, so count it
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_ff <= 10'h000;
    end else if (run_ff != 10'h3FF) begin
      run_ff <= run_ff + 10'h001;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  pon_hold_a: assert property (run_ff < 10'h1D6 |-> master_system_reset_o)
    else $error("power-on hold too short");
  pon_end_a: assert property (run_ff == 10'h208 |-> !master_system_reset_o)
    else $error("power-on hold too long");
  short_hold_a: assert property (soft_reset_i && !master_system_reset_o |=> master_system_reset_o
    ##180 master_system_reset_o ##[1:40] !master_system_reset_o) else $error("short hold wrong");
  brown_hold_a: assert property (brownout_i |=> master_system_reset_o ##300 master_system_reset_o
    ##[70:110] !master_system_reset_o) else $error("brownout hold wrong");
  wdt_fuse_a: assert property (watchdog_fuse_enable_i |-> watchdog_enable_o)
    else $error("fuse did not force watchdog");
  clk_fuse_a: assert property (brownout_i |-> ##[1:3] clock_select_o == fuse_clock_select_i)
    else $error("brownout clock not fuse");
  clk_nosw_a: assert property (soft_reset_i && !clock_switch_en_i |->
    ##[1:3] clock_select_o == fuse_clock_select_i) else $error("fixed clock not fuse");
  mon_off_a: assert property (master_system_reset_o |-> !monitor_enable_o)
    else $error("monitor on in reset");
  cover property (soft_reset_i);
  cover property (brownout_i);
  cover property ($fell(master_system_reset_o));
endmodule
`default_nettype wire

// File: dv/rcds_partner.sv
// Purpose: Model of the reset sources, core and crystal
// Assumes: Events are one-cycle pulses on the system clock
// Notes:   Crystal runs free at an eighth of the clock
`timescale 1ns/1ps
`default_nettype none
module rcds_partner (
  input  wire logic  clk_sys_i,          // System clock
  output logic       osc_pin_o = 1'b0,   // Crystal output
  output logic [9:0] ev_o = 10'h000      // Event pulses
);
  logic [1:0] div_ff = 2'h0; // Half-period count
  // Slow enough for the pin sampler to see every edge
  always @(posedge clk_sys_i) begin
    div_ff <= div_ff + 2'h1;
    if (div_ff == 2'h3) begin
      osc_pin_o <= !osc_pin_o;
    end
  end
  // One-cycle pulse on event k
  task automatic fire(input int k);
    @(posedge clk_sys_i);
    ev_o <= 10'h001 << k;
    @(posedge clk_sys_i);
    ev_o <= 10'h000;
  endtask
endmodule
`default_nettype wire

// File: dv/rcds_tb_top.sv
// Purpose: Self-checking bench of the reset sequencer
// Assumes: Start-up timer cut to 30 us, regulator on
// Notes:   Bus waits are bounded, never fixed
`timescale 1ns/1ps
`default_nettype none
module rcds_tb_top;
  logic        clk_sys_i = 1'b0; // Clock
  logic        reset_n_i = 1'b0; // Power-on reset
  logic [2:0]  addr = 3'h0;      // Bus address
  logic        rd_en = 1'b0;     // Bus read
  logic        wr_en = 1'b0;     // Bus write
  logic [31:0] wdata = 32'h0;    // Write data
  logic [3:0]  ben = 4'hF;       // Byte lanes
  logic [2:0]  fsel = 3'h2;      // Fuse clock source
  logic [2:0]  cur = 3'h4;       // Current clock source
  logic        xtal = 1'b1;      // Primary is a crystal
  logic        regen = 1'b1;     // Regulator on
  logic        pin_n = 1'b1;     // Reset pin
  logic        wdf = 1'b0;       // Watchdog fuse
  logic        csw = 1'b1;       // Clock switching
  logic [31:0] rdata;            // Read data
  logic [31:0] q;                // Last read
  logic [9:0]  ev;               // Events
  logic [2:0]  csel;             // Clock source
  logic        wait_rq, osc, msr, rdy, mon, wde, keep, whold; // Outputs
  int          bad_count = 0;    // Mismatches
  int          compares = 0;     // Comparisons
  int          bpos[8] = '{1, 15, 14, 9, 6, 4, 3, 2}; // Flag of event
  rcds_partner i_rcds_partner (.clk_sys_i(clk_sys_i), .osc_pin_o(osc), .ev_o(ev));
  rcds_top #(.PUT_US(30)) i_rcds_top (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .avs_address_i(addr), .avs_read_i(rd_en),
    .avs_write_i(wr_en), .avs_writedata_i(wdata), .avs_byteenable_i(ben),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_rq), .master_clear_pin_n_i(pin_n), .osc_pin_i(osc),
    .brownout_i(ev[0]), .trap_conflict_i(ev[1]), .bad_opcode_i(ev[2]), .config_mismatch_i(ev[3]),
    .soft_reset_i(ev[4]), .watchdog_timeout_i(ev[5]), .save_sleep_i(ev[6]), .save_idle_i(ev[7]),
    .watchdog_clear_i(ev[8]), .wake_i(ev[9]), .watchdog_fuse_enable_i(wdf), .fuse_clock_select_i(fsel),
    .current_clock_select_i(cur), .clock_switch_en_i(csw), .primary_crystal_i(xtal),
    .regulator_enable_i(regen), .master_system_reset_o(msr), .clock_select_o(csel), .clock_ready_o(rdy),
    .monitor_enable_o(mon), .watchdog_enable_o(wde), .regulator_sleep_keep_o(keep), .wake_hold_o(whold));
  initial begin
    forever #50 clk_sys_i = !clk_sys_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [2:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= {16'h0000, d};
    wr_en <= w;
    rd_en <= !w;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (wait_rq !== 1'b0 && n < 50);
    chk({31'h0, wait_rq}, 32'h00000000);
    q = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [31:0] e);
    bus(1'b0, a, 16'h0000);
    chk(q, e);
  endtask
  // Wait for system reset release, bounded
  task automatic wrel(input int lim);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    while (msr !== 1'b0 && n < lim) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk({31'h0, msr}, 32'h00000000);
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #3000000;
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    wrel(700);
    rd(3'h0, 32'h00000003);
    repeat (7500) @(posedge clk_sys_i);
    chk({31'h0, rdy}, 32'h00000000);
    repeat (1200) @(posedge clk_sys_i);
    rd(3'h4, 32'h0000002A);
    $display("power-on test done");
    ben <= 4'h2;
    bus(1'b1, 3'h0, 16'hFFFF);
    rd(3'h0, 32'h0000C303);
    ben <= 4'hF;
    bus(1'b1, 3'h0, 16'hFFFF);
    rd(3'h0, 32'h0000C3FF);
    chk({29'h0, msr, wde, keep}, 32'h00000003);
    bus(1'b1, 3'h0, 16'h0000);
    bus(1'b1, 3'h7, 16'hFFFF);
    wdf <= 1'b1;
    rd(3'h7, 32'h00000000);
    rd(3'h0, 32'h00000000);
    chk({29'h0, msr, wde, keep}, 32'h00000002);
    wdf <= 1'b0;
    $display("register test done");
    // Sleep keeps the earlier time-out flag to show that it clears it
    for (int k = 1; k < 8; k++) begin
      csw <= (k != 4);
      if (k != 6) bus(1'b1, 3'h0, 16'h0000);
      i_rcds_partner.fire(k);
      if (k < 6) wrel(400);
      rd(3'h0, 32'h1 << bpos[k]);
      chk({29'h0, csel}, (k == 4) ? 32'h00000002 : 32'h00000004);
    end
    i_rcds_partner.fire(5);
    wrel(400);
    i_rcds_partner.fire(8);
    rd(3'h0, 32'h00000004);
    $display("event test done");
    pin_n <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    pin_n <= 1'b1;
    wrel(500);
    rd(3'h0, 32'h00000084);
    bus(1'b1, 3'h0, 16'hFFFF);
    i_rcds_partner.fire(0);
    wrel(600);
    rd(3'h0, 32'h000001A3);
    chk({29'h0, csel}, 32'h00000002);
    i_rcds_partner.fire(9);
    @(posedge clk_sys_i);
    chk({30'h0, whold, msr}, 32'h00000002);
    regen <= 1'b0;
    repeat (250) @(posedge clk_sys_i);
    i_rcds_partner.fire(9);
    @(posedge clk_sys_i);
    chk({30'h0, whold, msr}, 32'h00000000);
    $display("reset test done");
    stop_test();
  end
endmodule
bind rcds_top rcds_props i_rcds_props (.*);
`default_nettype wire
